// ### logic/sec_core.sv
/*
 memory-side correction datapath and static configuration capture.
 assumes write words arrive as 64-bit groups on sys_clk and read beats
 return from the memory controller on sys_clk; configuration pins are
 static pins from outside the clock domain.
*/
`timescale 1ns/1ns
// Operation
// R1: fix every single-bit read error
// R2: multi-bit errors pass unflagged
// R3: eight check bits per 64-bit group
// R4: write group: two data beats, one check
// R5: decode check bits, correct, forward data
// R6: correction enable comes from arrangement code
// R7: decode arrangement codes to on/off
// R8: codes 100/110 documented both ways
// R9: organisation code selects part type
// R10: rate select picks 133 or 166MHz
// R11: host keeps port clock under 133MHz
// R12: port limits at 166MHz memory
// R13: port limits at 133MHz memory
// R14: narrower ports may run faster
// R15: usable capacity smaller, less when correcting
// R16: seven arrangements, fixed capacities each; code reports one only, the largest arrangement with 16Mx16 parts, others zero
// R17: check beat leaves 24 bits unused
// R18: configuration sampled during master reset; code captures it after reset release
// R19: 100/110 mapping is a build parameter
// R20: same hamming matrix both directions
module sec_core
	import sec_pkg::*;
#(
	parameter bit CODE100_IS_OFF = 1'b1
)(
	input  wire logic                 sys_clk,
	input  wire logic                 arst_n,
	input  wire logic [2:0]           memory_arrangement_code,
	input  wire logic [1:0]           memory_part_organisation,
	input  wire logic                 memory_clock_rate_select,
	input  wire logic                 wr_valid,
	input  wire logic [DATA_W-1:0]    wr_data,
	output logic                      wr_ready,
	output sec_beat_t                 mem_wr_beat,
	input  wire sec_beat_t            mem_rd_beat,
	output logic                      rd_valid,
	output logic      [DATA_W-1:0]    rd_data,
	output sec_cfg_t                  cfg,
	output logic      [10:0]          usable_mbit
);
	logic [2:0] arr_meta_reg;
	logic [2:0] arr_sync_reg;
	logic [1:0] org_meta_reg;
	logic [1:0] org_sync_reg;
	logic       spd_meta_reg;
	logic       spd_sync_reg;
	logic       cfg_lock_reg;
	sec_cfg_t   cfg_reg;
	sec_cfg_t   cfg_next;

	// arrangement code decode to class and correction enable
	function automatic logic code_on(input logic [2:0] c);
		case (c)
			ARR_A_ON, ARR_B_ON, ARR_C_ON: code_on = 1'b1; // R7
			ARR_D_LO:                     code_on = !CODE100_IS_OFF; // R8 R19
			ARR_D_HI:                     code_on = CODE100_IS_OFF; // R8 R19
			default:                      code_on = 1'b0;
		endcase
	endfunction

	function automatic sec_arr_t code_arr(input logic [2:0] c);
		case (c)
			ARR_A_OFF, ARR_A_ON: code_arr = SEC_ARR_ONE;
			ARR_B_OFF, ARR_B_ON: code_arr = SEC_ARR_TWO;
			ARR_C_OFF, ARR_C_ON: code_arr = SEC_ARR_WIDE;
			default:             code_arr = SEC_ARR_MID;
		endcase
	endfunction

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			arr_meta_reg <= CFG_RST_ARR;
			arr_sync_reg <= CFG_RST_ARR;
			org_meta_reg <= CFG_RST_ORG;
			org_sync_reg <= CFG_RST_ORG;
			spd_meta_reg <= 1'b0;
			spd_sync_reg <= 1'b0;
		end else begin
			arr_meta_reg <= memory_arrangement_code;
			arr_sync_reg <= arr_meta_reg;
			org_meta_reg <= memory_part_organisation;
			org_sync_reg <= org_meta_reg;
			spd_meta_reg <= memory_clock_rate_select;
			spd_sync_reg <= spd_meta_reg;
		end
	end

	always_comb begin
		cfg_next              = cfg_reg;
		cfg_next.arrangement  = code_arr(arr_sync_reg);
		cfg_next.correct_en   = code_on(arr_sync_reg); // R6
		cfg_next.organisation = org_sync_reg; // R9
		cfg_next.org_valid    = (org_sync_reg == ORG_4MX32) || (org_sync_reg == ORG_8MX32)
			|| (org_sync_reg == ORG_16MX16);
		cfg_next.rate_166     = spd_sync_reg; // R10
	end

	// sampled once, three cycles after reset release, then held static
	logic [1:0] lock_cnt_reg;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_cnt_reg <= 2'h0;
			cfg_lock_reg <= 1'b0;
			cfg_reg      <= '0;
		end else if (!cfg_lock_reg) begin
			lock_cnt_reg <= lock_cnt_reg + 2'h1;
			if (lock_cnt_reg == 2'h2) begin
				cfg_reg      <= cfg_next; // R18
				cfg_lock_reg <= 1'b1;
			end
		end
	end

	assign cfg = cfg_reg;

	// capacity for the largest arrangement with 16Mx16 parts only; others reported zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			usable_mbit <= 11'h0;
		end else if (cfg_reg.arrangement == SEC_ARR_WIDE && cfg_reg.organisation == ORG_16MX16) begin
			usable_mbit <= cfg_reg.correct_en ? CAP_16X16_X4_ON : CAP_16X16_X4_OFF; // R15 R16
		end else begin
			usable_mbit <= 11'h0;
		end
	end

	logic [DATA_W-1:0]  enc_in;
	logic [CHECK_W-1:0] enc_check;
	logic [DATA_W-1:0]  dec_in;
	logic [CHECK_W-1:0] dec_check;
	logic [DATA_W-1:0]  dec_fixed;

	sec_hamming u_ham (
		.enc_data   (enc_in),
		.enc_check  (enc_check),
		.dec_data   (dec_in),
		.dec_check  (dec_check),
		.dec_fixed  (dec_fixed),
		.dec_single ()
	);

	// write side beat sequencer
	logic [1:0]         wbeat_reg;
	logic               wbusy_reg;
	logic [DATA_W-1:0]  wdata_reg;
	logic [CHECK_W-1:0] wcheck_reg;

	assign wr_ready = !wbusy_reg && cfg_lock_reg;
	assign enc_in   = wr_data;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wbusy_reg  <= 1'b0;
			wbeat_reg  <= 2'h0;
			wdata_reg  <= '0;
			wcheck_reg <= '0;
		end else if (wr_valid && wr_ready) begin
			wbusy_reg  <= 1'b1;
			wbeat_reg  <= 2'h0;
			wdata_reg  <= wr_data;
			wcheck_reg <= enc_check; // R3
		end else if (wbusy_reg) begin
			wbeat_reg <= wbeat_reg + 2'h1;
			if (wbeat_reg == 2'(cfg_reg.correct_en ? CHECK_BEAT : BEATS_DATA - 1))
				wbusy_reg <= 1'b0; // R4
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_wr_beat <= '0;
		end else if (wbusy_reg) begin
			mem_wr_beat.valid <= 1'b1;
			mem_wr_beat.check <= (wbeat_reg == 2'(CHECK_BEAT));
			case (wbeat_reg)
				2'h0:    mem_wr_beat.data <= wdata_reg[BEAT_W-1:0];
				2'h1:    mem_wr_beat.data <= wdata_reg[DATA_W-1:BEAT_W];
				default: mem_wr_beat.data <= {{CKPAD_W{1'b0}}, wcheck_reg}; // R17
			endcase
		end else begin
			mem_wr_beat <= '0;
		end
	end

	// read side: gather beats, then correct
	logic [1:0]         rbeat_reg;
	logic [DATA_W-1:0]  rdata_reg;
	logic [CHECK_W-1:0] rcheck_reg;
	logic               rdone_reg;

	assign dec_in    = rdata_reg;
	assign dec_check = rcheck_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rbeat_reg  <= 2'h0;
			rdata_reg  <= '0;
			rcheck_reg <= '0;
			rdone_reg  <= 1'b0;
		end else begin
			rdone_reg <= 1'b0;
			if (mem_rd_beat.valid) begin
				rbeat_reg <= rbeat_reg + 2'h1;
				case (rbeat_reg)
					2'h0:    rdata_reg[BEAT_W-1:0] <= mem_rd_beat.data;
					2'h1:    rdata_reg[DATA_W-1:BEAT_W] <= mem_rd_beat.data;
					default: rcheck_reg <= mem_rd_beat.data[CHECK_W-1:0];
				endcase
				if (rbeat_reg == 2'(cfg_reg.correct_en ? CHECK_BEAT : BEATS_DATA - 1)) begin
					rbeat_reg <= 2'h0;
					rdone_reg <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_valid <= 1'b0;
			rd_data  <= '0;
		end else begin
			rd_valid <= rdone_reg;
			if (rdone_reg)
				rd_data <= cfg_reg.correct_en ? dec_fixed : rdata_reg; // R5 R1 R2
		end
	end
endmodule // sec_core

// ### inc/sec_pkg.sv
/*
 package for the memory-side error correction and configuration block:
 configuration encodings, code layout, burst beats, reset values, capacities.
 assumes nothing beyond a systemverilog compiler.
*/
package sec_pkg;
	localparam int DATA_W      = 64;
	localparam int CHECK_W     = 8;
	localparam int HAM_W       = 7;
	localparam int CODE_W      = 71;
	localparam int BEAT_W      = 32;
	localparam int BEATS_DATA  = 2;
	localparam int CHECK_BEAT  = 2;
	localparam int CKPAD_W     = 24;

	localparam logic [2:0] ARR_A_OFF  = 3'h0;
	localparam logic [2:0] ARR_A_ON   = 3'h2;
	localparam logic [2:0] ARR_B_OFF  = 3'h1;
	localparam logic [2:0] ARR_B_ON   = 3'h3;
	localparam logic [2:0] ARR_C_OFF  = 3'h7;
	localparam logic [2:0] ARR_C_ON   = 3'h5;
	localparam logic [2:0] ARR_D_LO   = 3'h4;
	localparam logic [2:0] ARR_D_HI   = 3'h6;

	localparam logic [1:0] ORG_4MX32  = 2'h0;
	localparam logic [1:0] ORG_8MX32  = 2'h2;
	localparam logic [1:0] ORG_16MX16 = 2'h3;

	localparam logic [2:0] CFG_RST_ARR = 3'h0;
	localparam logic [1:0] CFG_RST_ORG = 2'h0;

	localparam logic [10:0] CAP_16X16_X4_OFF = 11'h3F0;
	localparam logic [10:0] CAP_16X16_X4_ON  = 11'h240;

	typedef enum logic [1:0] {SEC_ARR_ONE, SEC_ARR_TWO, SEC_ARR_WIDE, SEC_ARR_MID} sec_arr_t;

	typedef struct packed {
		sec_arr_t    arrangement;
		logic        correct_en;
		logic [1:0]  organisation;
		logic        rate_166;
		logic        org_valid;
	} sec_cfg_t;

	typedef struct packed {
		logic              valid;
		logic [BEAT_W-1:0] data;
		logic              check;
	} sec_beat_t;
endpackage

// ### logic/sec_hamming.sv
/*
 single-error-correcting hamming code generator and checker over 64 bits.
 assumes callers use this same module for encoding and decoding.
*/
`timescale 1ns/1ns
module sec_hamming
	import sec_pkg::*;
(
	input  wire logic [DATA_W-1:0]  enc_data,
	output logic      [CHECK_W-1:0] enc_check,
	input  wire logic [DATA_W-1:0]  dec_data,
	input  wire logic [CHECK_W-1:0] dec_check,
	output logic      [DATA_W-1:0]  dec_fixed,
	output logic                    dec_single
);
	// code position (1..71, skipping powers of two) of each data bit
	function automatic logic [HAM_W-1:0] pos_of(input int idx);
		int p;
		int n;
		p = 0;
		n = -1;
		while (n < idx) begin
			p = p + 1;
			if ((p & (p - 1)) != 0)
				n = n + 1;
		end
		return HAM_W'(p);
	endfunction

	function automatic logic [HAM_W-1:0] synd(input logic [DATA_W-1:0] d);
		logic [HAM_W-1:0] s;
		s = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (d[i])
				s = s ^ pos_of(i);
		end
		return s;
	endfunction

	logic [HAM_W-1:0] s_dec;

	always_comb begin
		enc_check = {1'b0, synd(enc_data)}; // R20
	end

	always_comb begin
		s_dec      = synd(dec_data) ^ dec_check[HAM_W-1:0]; // R20
		dec_fixed  = dec_data;
		dec_single = (s_dec != '0);
		for (int i = 0; i < DATA_W; i++) begin
			if (s_dec == pos_of(i))
				dec_fixed[i] = ~dec_data[i]; // R1
		end
	end
endmodule // sec_hamming

// ### testbench/sec_checker.sv
/*
 port checker for sec_core.
 assumes it is bound to sec_core.
*/
`timescale 1ns/1ns
module sec_checker
	import sec_pkg::*;
#(
	parameter bit CODE100_IS_OFF = 1'b1
)(
	input wire logic              sys_clk,
	input wire logic              arst_n,
	input wire logic [2:0]        memory_arrangement_code,
	input wire logic [1:0]        memory_part_organisation,
	input wire logic              memory_clock_rate_select,
	input wire logic              wr_valid,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic              wr_ready,
	input wire sec_beat_t         mem_wr_beat,
	input wire sec_beat_t         mem_rd_beat,
	input wire logic              rd_valid,
	input wire logic [DATA_W-1:0] rd_data,
	input wire sec_cfg_t          cfg,
	input wire logic [10:0]       usable_mbit
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic [63:0] held_reg;
	logic        take;
	logic        on_exp;
	logic [2:0]  mac;
	assign mac = memory_arrangement_code;
	assign take = wr_valid && wr_ready;
	assign on_exp = mac inside {3'h2, 3'h3, 3'h5} || mac == (CODE100_IS_OFF ? 3'h6 : 3'h4);
	always_ff @(posedge sys_clk) begin
		if (take) held_reg <= wr_data;
	end
	property p_beats; take |-> ##2 mem_wr_beat.valid ##1 mem_wr_beat.valid; endproperty
	a_beats: assert property (p_beats) else $error("data beats missing");
	property p_order;
		take |-> ##2 mem_wr_beat.data == held_reg[31:0] ##1 mem_wr_beat.data == held_reg[63:32];
	endproperty
	a_order: assert property (p_order) else $error("beat order wrong");
	property p_chk; take && cfg.correct_en |-> ##4 mem_wr_beat.valid && mem_wr_beat.check; endproperty
	a_chk: assert property (p_chk) else $error("check beat missing");
	property p_nochk; take && !cfg.correct_en |-> ##4 !mem_wr_beat.valid; endproperty
	a_nochk: assert property (p_nochk) else $error("extra beat");
	property p_pad; mem_wr_beat.check |-> mem_wr_beat.data[31:8] == 24'h0; endproperty
	a_pad: assert property (p_pad) else $error("pad not zero");
	property p_lock; $past(wr_ready) |-> $stable(cfg); endproperty
	a_lock: assert property (p_lock) else $error("cfg moved");
	property p_map; wr_ready |-> cfg.correct_en == on_exp; endproperty
	a_map: assert property (p_map) else $error("enable map wrong");
	property p_cfg;
		wr_ready |-> cfg.organisation == memory_part_organisation
			&& cfg.rate_166 == memory_clock_rate_select;
	endproperty
	a_cfg: assert property (p_cfg) else $error("org or rate wrong");
	property p_cap;
		wr_ready && $past(wr_ready) && memory_part_organisation == 2'h3 && mac inside {3'h5, 3'h7}
			|-> usable_mbit == (mac == 3'h7 ? 11'h3F0 : 11'h240);
	endproperty
	a_cap: assert property (p_cap) else $error("capacity wrong");
	property p_busy; take |=> !wr_ready [*2] ##1 (wr_ready == !cfg.correct_en); endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_rd; rd_valid |-> $past(mem_rd_beat.valid, 2); endproperty
	a_rd: assert property (p_rd) else $error("read answer early");
	cover property (take && cfg.correct_en);
	cover property (take && !cfg.correct_en);
	cover property (rd_valid);
endmodule // sec_checker
bind sec_core sec_checker #(.CODE100_IS_OFF(CODE100_IS_OFF)) chk_u (.sys_clk, .arst_n,
	.memory_arrangement_code, .memory_part_organisation, .memory_clock_rate_select,
	.wr_valid, .wr_data, .wr_ready, .mem_wr_beat, .mem_rd_beat, .rd_valid, .rd_data,
	.cfg, .usable_mbit);

// ### testbench/sec_mem_model.sv
/*
 memory model: keeps the last write group, plays it back on request.
 assumes write beats of one group come back to back.
*/
`timescale 1ns/1ns
module sec_mem_model
	import sec_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire sec_beat_t   mem_wr_beat,
	input  wire logic        rd_go,
	input  wire logic        with_check,
	input  wire logic        slow,
	input  wire logic [95:0] flip_mask,
	output sec_beat_t        mem_rd_beat
);
	logic [31:0] store_reg [3];
	int          wptr = 0;
	int          idx = 0;
	int          gap = 0;
	bit          busy = 0;
	initial mem_rd_beat = '0;
	always @(posedge sys_clk) begin
		if (mem_wr_beat.valid) store_reg[wptr] <= mem_wr_beat.data;
		wptr <= mem_wr_beat.valid ? wptr + 1 : 0;
		if (rd_go) begin
			busy = 1;
			idx = 0;
			gap = 0;
		end
		if (busy && gap == 0) begin
			mem_rd_beat <= '{1'h1, store_reg[idx] ^ flip_mask[32*idx +: 32], idx == 2};
			idx++;
			gap = slow;
			busy = idx < (with_check ? 3 : 2);
		end else begin
			mem_rd_beat <= '{1'h0, ~mem_rd_beat.data, 1'h0};
			if (gap > 0) gap--;
		end
	end
endmodule // sec_mem_model

// ### testbench/sec_core_tb.sv
/*
 testbench for sec_core: all arrangement codes, writes, faulty reads.
 assumes sec_mem_model stands at the memory side.
*/
`timescale 1ns/1ns
module sec_core_tb
	import sec_pkg::*;
;
	logic        sys_clk = 0, arst_n = 0, wr_valid = 0, rate = 0, rd_go = 0, slow = 0, on = 0;
	logic [2:0]  code = 0;
	logic [1:0]  org = 0;
	logic [63:0] wr_data = 0;
	logic [95:0] fm = 0;
	logic        wr_ready, rd_valid;
	logic [63:0] rd_data;
	logic [10:0] usable_mbit;
	sec_beat_t   wb, rb;
	sec_cfg_t    cfg;
	int          err_count = 0, checked = 0, cyc = 0;
	integer      seed = 32'hbd50;
	initial forever #5 sys_clk = ~sys_clk;
	sec_core dut_u (.sys_clk, .arst_n, .memory_arrangement_code(code),
		.memory_part_organisation(org), .memory_clock_rate_select(rate), .wr_valid,
		.wr_data, .wr_ready, .mem_wr_beat(wb), .mem_rd_beat(rb), .rd_valid, .rd_data,
		.cfg, .usable_mbit);
	sec_mem_model mem_u (.sys_clk, .mem_wr_beat(wb), .rd_go, .with_check(on), .slow,
		.flip_mask(fm), .mem_rd_beat(rb));
	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [10:0] cap_of(input logic [2:0] c, input logic [1:0] o);
		return o != 2'h3 ? 11'h0 : c == 3'h7 ? 11'h3F0 : c == 3'h5 ? 11'h240 : 11'h0;
	endfunction
	function automatic sec_arr_t arr_of(input logic [2:0] c);
		return c inside {3'h0, 3'h2} ? SEC_ARR_ONE : c inside {3'h1, 3'h3} ? SEC_ARR_TWO
			: c inside {3'h5, 3'h7} ? SEC_ARR_WIDE : SEC_ARR_MID;
	endfunction
	task automatic xfer(input logic [63:0] d, input logic [95:0] m, input logic sl);
		wr_valid <= 1'h1;
		wr_data <= d;
		@(negedge sys_clk);
		while (wr_ready !== 1'h1) @(negedge sys_clk);
		@(posedge sys_clk);
		wr_valid <= 1'h0;
		repeat (5) @(posedge sys_clk);
		fm <= m;
		slow <= sl;
		rd_go <= 1'h1;
		@(posedge sys_clk);
		rd_go <= 1'h0;
		repeat (12) begin
			@(negedge sys_clk);
			if (rd_valid === 1'h1) break;
		end
		chk("rd_valid", 64'h1, rd_valid);
		chk("rd_data", on ? d : d ^ m[63:0], rd_data);
		@(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		for (int c = 0; c < 8; c++) begin
			arst_n <= 1'h0;
			code <= c[2:0];
			org <= c[0] ? 2'h3 : 2'($random(seed));
			rate <= 1'($random(seed));
			on <= c[2:0] inside {3'h2, 3'h3, 3'h5, 3'h6};
			repeat (4) @(posedge sys_clk);
			arst_n <= 1'h1;
			repeat (5) @(posedge sys_clk);
			chk("correct_en", on, cfg.correct_en);
			chk("arrangement", arr_of(code), cfg.arrangement);
			chk("organisation", org, cfg.organisation);
			chk("org_valid", org != 2'h1, cfg.org_valid);
			chk("rate_166", rate, cfg.rate_166);
			chk("usable_mbit", cap_of(code, org), usable_mbit);
			xfer(64'hFFFF_FFFF_0000_0001, 96'h1, 1'h1);
			xfer(64'h8000_0000_0000_0000, 96'h1 << 63, 1'h0);
			if (on) xfer(64'($random(seed)), 96'h1 << 64, 1'h1);
			repeat (4) xfer({$random(seed), $random(seed)},
				96'h1 << ($unsigned($random(seed)) % (on ? 72 : 64)), 1'($random(seed)));
			wr_valid <= 1'h1;
			repeat (12) @(posedge sys_clk);
			wr_valid <= 1'h0;
			repeat (6) @(posedge sys_clk);
			$display("config code %0d done", c);
		end
		give_verdict();
	end
endmodule // sec_core_tb
